// [mmdec_checker.sv]
// Checker for the address decoder top-level ports.
// Assumes one clock domain and outputs one cycle after the address.
`timescale 1ns/10ps
module mmdec_checker
  import mmdec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire mmdec_req_s busReq,
  input wire mmdec_res_s decode,
  input wire logic selValid,
  input wire logic monRomSel,
  input wire logic zeroPageSel,
  input wire logic [12:0] highPageSel,
  input wire logic flash_block_protect_reg_sel,
  input wire logic vectorSel,
  input wire logic securitySel,
  input wire logic reservedHit,
  input wire logic illegalAddrReset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // Access sequences
  sequence s_in(logic [15:0] lo, logic [15:0] hi);
    busReq.valid && busReq.addr >= lo && busReq.addr <= hi;
  endsequence
  property p_zp;
    s_in(ZP_LO, ZP_HI) |=> zeroPageSel && decode.region == MMDEC_ZPAGE;
  endproperty
  a_zp: assert property (p_zp) else $error("zero page select missing");
  property p_una;
    s_in(UNA_LO, UNB_HI) |=> illegalAddrReset;
  endproperty
  a_una: assert property (p_una) else $error("no illegal request");
  property p_unc;
    s_in(UNC_LO, UNC_HI) |=> illegalAddrReset && !vectorSel;
  endproperty
  a_unc: assert property (p_unc) else $error("no illegal request");
  property p_mon;
    s_in(MON_LO, MON_HI) |=> monRomSel && !illegalAddrReset;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor select missing");
  property p_fbp;
    s_in(FBP_ADDR, FBP_ADDR) |=> flash_block_protect_reg_sel;
  endproperty
  a_fbp: assert property (p_fbp) else $error("protect select missing");
  property p_vec;
    s_in(VEC_LO, VEC_HI) |=> vectorSel && !illegalAddrReset &&
      decode.offset == 16'($past(busReq.addr) - VEC_LO);
  endproperty
  a_vec: assert property (p_vec) else $error("vector select missing");
  property p_sec;
    busReq.valid |=> securitySel == (vectorSel && decode.secByte);
  endproperty
  a_sec: assert property (p_sec) else $error("security select wrong");
  property p_hp;
    s_in(HP_LO, HP_HI) |=>
      highPageSel == ((13'h1 << ($past(busReq.addr) - HP_LO)) & 13'h1F7F);
  endproperty
  a_hp: assert property (p_hp) else $error("high page select wrong");
  property p_rsvd;
    s_in(HP_RSVD, HP_RSVD) |=> reservedHit && !illegalAddrReset;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved hit wrong");
  property p_idle;
    !busReq.valid |=> !selValid && !illegalAddrReset && highPageSel == 13'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("select without access");
endmodule : mmdec_checker
bind mmdec_top mmdec_checker i_mmdec_checker (.clk_sys, .reset_n, .busReq,
  .decode, .selValid, .monRomSel, .zeroPageSel, .highPageSel,
  .flash_block_protect_reg_sel, .vectorSel, .securitySel, .reservedHit,
  .illegalAddrReset);

// [mmdec_cpu.sv]
// Processor core model that presents one address per request.
// Assumes the bench calls drive once per clock cycle at most.
`timescale 1ns/10ps
module mmdec_cpu
  import mmdec_pkg::*;
(
  input wire logic clk_sys,
  output mmdec_req_s busReq
);
  // Idles with no access on a harmless address
  initial busReq = '{16'h0000, 1'b0};
  task automatic drive(input logic [15:0] a, input logic v);
    @(posedge clk_sys);
    #1 busReq = '{a, v};
  endtask : drive
endmodule : mmdec_cpu

// [mmdec_pkg.sv]
// Constants and types for the memory map address decoder.
// Assumes a 16-bit byte address from the processor core.
package mmdec_pkg;

  // ==========================================================
  // Address space
  localparam int ADDR_W = 16;
  localparam int SPACE_BYTES = 65536;

  // ==========================================================
  // Fixed region bounds
  localparam logic [15:0] ZP_LO = 16'h0000;
  localparam logic [15:0] ZP_HI = 16'h003F;
  localparam logic [15:0] HP_LO = 16'hFE00;
  localparam logic [15:0] HP_HI = 16'hFE0C;
  localparam logic [15:0] HP_RSVD = 16'hFE07;
  localparam logic [15:0] UNA_LO = 16'hFE0D;
  localparam logic [15:0] UNA_HI = 16'hFE0F;
  localparam logic [15:0] UNB_LO = 16'hFE10;
  localparam logic [15:0] UNB_HI = 16'hFE1F;
  localparam logic [15:0] MON_LO = 16'hFE20;
  localparam logic [15:0] MON_HI = 16'hFF7D;
  localparam logic [15:0] FBP_ADDR = 16'hFF7E;
  localparam logic [15:0] UNC_LO = 16'hFF7F;
  localparam logic [15:0] UNC_HI = 16'hFFD3;
  localparam logic [15:0] VEC_LO = 16'hFFD4;
  localparam logic [15:0] VEC_HI = 16'hFFFF;
  localparam logic [15:0] SEC_LO = 16'hFFF6;
  localparam logic [15:0] SEC_HI = 16'hFFFD;

  // ==========================================================
  // Sized regions with parameterised bases
  localparam logic [15:0] RAM_SIZE = 16'h0400;
  localparam logic [15:0] FLASH_SIZE = 16'h1E00;
  localparam logic [15:0] PROG_SIZE = 16'h0196;
  localparam logic [15:0] RAM_BASE_DEF = 16'h0040;
  localparam logic [15:0] FLASH_BASE_DEF = 16'hE000;
  // Routine ROM default sits in a free area so flash cannot shadow it
  localparam logic [15:0] PROG_BASE_DEF = 16'h0800;

  // ==========================================================
  // Region codes
  typedef enum logic [3:0] {
    MMDEC_UNIMPL = 4'h0,
    MMDEC_ZPAGE = 4'h1,
    MMDEC_HPAGE = 4'h2,
    MMDEC_RSVD = 4'h3,
    MMDEC_MONROM = 4'h4,
    MMDEC_FBPROT = 4'h5,
    MMDEC_VECTOR = 4'h6,
    MMDEC_RAM = 4'h7,
    MMDEC_FLASH = 4'h8,
    MMDEC_PROGROM = 4'h9
  } mmdec_region_e;

  typedef struct packed {
    logic [15:0] addr;
    logic valid;
  } mmdec_req_s;

  typedef struct packed {
    mmdec_region_e region;
    logic [15:0] offset;
    logic [3:0] hpIndex;
    logic secByte;
    logic illegal;
  } mmdec_res_s;

endpackage : mmdec_pkg

// [mmdec_region.sv]
// Combinational region classifier for one address.
// Assumes bases do not overlap the fixed regions or each other.
`timescale 1ns/10ps
module mmdec_region
  import mmdec_pkg::*;
#(
  parameter logic [15:0] RAM_BASE = RAM_BASE_DEF,
  parameter logic [15:0] FLASH_BASE = FLASH_BASE_DEF,
  parameter logic [15:0] PROG_BASE = PROG_BASE_DEF
) (
  input wire logic [15:0] addr,
  output mmdec_res_s res
);

  function automatic logic inRange(input logic [15:0] a,
      input logic [15:0] lo, input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  function automatic logic inSized(input logic [15:0] a,
      input logic [15:0] base, input logic [15:0] size);
    logic [16:0] top;
    top = {1'b0, base} + {1'b0, size};
    inSized = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < top);
  endfunction : inSized

  wire logic hitZp = inRange(addr, ZP_LO, ZP_HI);
  wire logic hitHp = inRange(addr, HP_LO, HP_HI);
  wire logic hitRsvd = hitHp && (addr == HP_RSVD);
  wire logic hitMon = inRange(addr, MON_LO, MON_HI);
  wire logic hitFbp = (addr == FBP_ADDR);
  wire logic hitVec = inRange(addr, VEC_LO, VEC_HI);
  wire logic hitSec = inRange(addr, SEC_LO, SEC_HI);
  wire logic hitRam = inSized(addr, RAM_BASE, RAM_SIZE);
  wire logic hitFlash = inSized(addr, FLASH_BASE, FLASH_SIZE);
  wire logic hitProg = inSized(addr, PROG_BASE, PROG_SIZE);

  // Priority keeps exactly one region; fixed regions win over bases
  wire mmdec_region_e region =
      hitZp ? MMDEC_ZPAGE :
      hitRsvd ? MMDEC_RSVD :
      hitHp ? MMDEC_HPAGE :
      hitMon ? MMDEC_MONROM :
      hitFbp ? MMDEC_FBPROT :
      hitVec ? MMDEC_VECTOR :
      hitRam ? MMDEC_RAM :
      hitFlash ? MMDEC_FLASH :
      hitProg ? MMDEC_PROGROM :
      MMDEC_UNIMPL;

  wire logic [15:0] base =
      (region == MMDEC_RAM) ? RAM_BASE :
      (region == MMDEC_FLASH) ? FLASH_BASE :
      (region == MMDEC_PROGROM) ? PROG_BASE :
      (region == MMDEC_MONROM) ? MON_LO :
      (region == MMDEC_VECTOR) ? VEC_LO :
      (region == MMDEC_HPAGE || region == MMDEC_RSVD) ? HP_LO :
      16'h0000;

  wire logic [15:0] diff = addr - base;

  assign res.region = region;
  assign res.offset = diff;
  assign res.hpIndex = hitHp ? diff[3:0] : 4'h0;
  assign res.secByte = hitSec;
  assign res.illegal = (region == MMDEC_UNIMPL);

endmodule : mmdec_region

// [mmdec_top.sv]
// Registered memory map address decoder for the system bus.
// Assumes the core presents a same-clock address with a valid strobe.
`timescale 1ns/10ps

// Overview of operation
// - Every 16-bit address falls into exactly one region.
// - Hex 0000 to 003F selects the zero-page peripheral registers.
// - A valid access to an unimplemented address pulses an illegal reset request.
// - Hex FE00 to FE0C select high-page registers; FE07 is reserved.
// - Hex FE0D to FE0F are unimplemented.
// - Hex FE10 to FE1F are unimplemented, kept for older monitor code.
// - Hex FE20 to FF7D select the 350-byte monitor ROM.
// - Hex FF7E selects the flash block-protection register.
// - Hex FF7F to FFD3 are unimplemented.
// - Hex FFD4 to FFFF select the 44-byte user vector area.
// - Hex FFF6 to FFFD are flagged as security bytes.
// - A 1024-byte RAM region is decoded.
// - A 7680-byte user flash region is decoded.
// - A 406-byte programming-routine ROM region is decoded.
module mmdec_top
  import mmdec_pkg::*;
#(
  parameter logic [15:0] RAM_BASE = RAM_BASE_DEF,
  parameter logic [15:0] FLASH_BASE = FLASH_BASE_DEF,
  parameter logic [15:0] PROG_BASE = PROG_BASE_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire mmdec_req_s busReq,
  output mmdec_res_s decode,
  output logic selValid,
  output logic ramSel,
  output logic flashSel,
  output logic progRomSel,
  output logic monRomSel,
  output logic zeroPageSel,
  output logic [12:0] highPageSel,
  output logic flash_block_protect_reg_sel,
  output logic vectorSel,
  output logic securitySel,
  output logic reservedHit,
  output logic illegalAddrReset
);

  // ==========================================================
  // Classification
  mmdec_res_s res;

  mmdec_region #(
    .RAM_BASE(RAM_BASE),
    .FLASH_BASE(FLASH_BASE),
    .PROG_BASE(PROG_BASE)
  ) u_region (
    .addr(busReq.addr),
    .res(res)
  );

  wire logic v = busReq.valid;
  wire logic next_ram = v && (res.region == MMDEC_RAM);
  wire logic next_flash = v && (res.region == MMDEC_FLASH);
  wire logic next_prog = v && (res.region == MMDEC_PROGROM);
  wire logic next_mon = v && (res.region == MMDEC_MONROM);
  wire logic next_zp = v && (res.region == MMDEC_ZPAGE);
  wire logic next_fbp = v && (res.region == MMDEC_FBPROT);
  wire logic next_vec = v && (res.region == MMDEC_VECTOR);
  wire logic next_sec = v && res.secByte;
  // Reserved accesses are only reported; software keeps clear of them
  wire logic next_rsvd = v && (res.region == MMDEC_RSVD);
  wire logic next_illegal = v && res.illegal;

  // ==========================================================
  // One-hot high-page register selects
  logic [12:0] next_hp;
  genvar i;
  generate
    for (i = 0; i < 13; i++) begin : g_hp
      assign next_hp[i] = v && (res.region == MMDEC_HPAGE) &&
          (res.hpIndex == 4'(i));
    end
  endgenerate

  // ==========================================================
  // Output registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      decode <= '0;
      selValid <= 1'b0;
      ramSel <= 1'b0;
      flashSel <= 1'b0;
      progRomSel <= 1'b0;
      monRomSel <= 1'b0;
      zeroPageSel <= 1'b0;
      highPageSel <= 13'h0000;
      flash_block_protect_reg_sel <= 1'b0;
      vectorSel <= 1'b0;
      securitySel <= 1'b0;
      reservedHit <= 1'b0;
      illegalAddrReset <= 1'b0;
    end else begin
      decode <= res;
      selValid <= v;
      ramSel <= next_ram;
      flashSel <= next_flash;
      progRomSel <= next_prog;
      monRomSel <= next_mon;
      zeroPageSel <= next_zp;
      highPageSel <= next_hp;
      flash_block_protect_reg_sel <= next_fbp;
      vectorSel <= next_vec;
      securitySel <= next_sec;
      reservedHit <= next_rsvd;
      illegalAddrReset <= next_illegal;
    end
  end

endmodule : mmdec_top

// [tb.sv]
// Self-checking bench for the address decoder.
// Assumes routine ROM moved to 0800 so no region is shadowed.
`timescale 1ns/10ps
module tb
  import mmdec_pkg::*;
;
  logic clk_sys = 0, reset_n = 0;
  int n_errors = 0, n_checks = 0, cyc = 0;
  mmdec_req_s busReq;
  mmdec_res_s decode;
  logic selValid, ramSel, flashSel, progRomSel, monRomSel, zeroPageSel;
  logic flash_block_protect_reg_sel, vectorSel, securitySel, reservedHit;
  logic illegalAddrReset;
  logic [12:0] highPageSel;
  wire logic [7:0] sels = {ramSel, flashSel, progRomSel, monRomSel,
    zeroPageSel, flash_block_protect_reg_sel, vectorSel, reservedHit};
  // Rows: address, region code, offset
  localparam logic [35:0] ROWS [22] = '{36'h0000_1_0000, 36'h003F_1_003F,
    36'hFE00_2_0000, 36'hFE07_3_0007, 36'hFE0C_2_000C, 36'hFE0D_0_FE0D,
    36'hFE1F_0_FE1F, 36'hFE20_4_0000, 36'hFF7D_4_015D, 36'hFF7E_5_FF7E,
    36'hFF7F_0_FF7F, 36'hFFD3_0_FFD3, 36'hFFD4_6_0000, 36'hFFFF_6_002B,
    36'h0040_7_0000, 36'h043F_7_03FF, 36'h0440_0_0440, 36'hE000_8_0000,
    36'hFDFF_8_1DFF, 36'h0800_9_0000, 36'h0995_9_0195, 36'h0996_0_0996};
  mmdec_cpu i_mmdec_cpu (.clk_sys, .busReq);
  mmdec_top #(.PROG_BASE(16'h0800)) i_mmdec_top (.clk_sys, .reset_n,
    .busReq, .decode, .selValid, .ramSel, .flashSel, .progRomSel,
    .monRomSel, .zeroPageSel, .highPageSel, .flash_block_protect_reg_sel,
    .vectorSel, .securitySel, .reservedHit, .illegalAddrReset);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [15:0] e, s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Expected single-bit selects, in the order of sels
  function automatic logic [15:0] expSel(input logic [3:0] r);
    expSel = {8'h00, r == 4'h7, r == 4'h8, r == 4'h9, r == 4'h4,
      r == 4'h1, r == 4'h5, r == 4'h6, r == 4'h3};
  endfunction : expSel
  task automatic go(input logic [15:0] a, input logic v);
    i_mmdec_cpu.drive(a, v);
    @(posedge clk_sys);
    #2;
  endtask : go
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    @(posedge clk_sys);
    #2 chk("reset illegal", 16'h0, illegalAddrReset);
    chk("reset region", 16'h0, decode.region);
    @(posedge clk_sys);
    #1 reset_n = 1;
    $display("reset test done");
    foreach (ROWS[i]) begin
      go(ROWS[i][35:20], 1'b1);
      chk("region", ROWS[i][19:16], decode.region);
      chk("offset", ROWS[i][15:0], decode.offset);
      chk("illegal", ROWS[i][19:16] == 4'h0, illegalAddrReset);
      chk("decode illegal", ROWS[i][19:16] == 4'h0, decode.illegal);
      chk("valid", 16'h0001, selValid);
      chk("selects", expSel(ROWS[i][19:16]), sels);
      chk("hp index", (ROWS[i][19:16] inside {4'h2, 4'h3}) ?
        {12'h000, ROWS[i][3:0]} : 16'h0000, decode.hpIndex);
      chk("hp select", (ROWS[i][19:16] == 4'h2) ?
        16'h0001 << ROWS[i][3:0] : 16'h0000, highPageSel);
    end
    $display("table test done");
    for (int a = 16'hFFF5; a <= 16'hFFFE; a++) begin
      go(a[15:0], 1'b1);
      chk("security", a >= 16'hFFF6 && a <= 16'hFFFD, securitySel);
      chk("sec byte", a >= 16'hFFF6 && a <= 16'hFFFD, decode.secByte);
    end
    go(16'hFE03, 1'b1);
    chk("high page", 16'h0008, highPageSel);
    go(16'h0040, 1'b1);
    chk("ram", 16'h4, {ramSel, flashSel, progRomSel});
    go(16'hFDFF, 1'b1);
    chk("flash", 16'h2, {ramSel, flashSel, progRomSel});
    go(16'h0995, 1'b1);
    chk("routine rom", 16'h1, {ramSel, flashSel, progRomSel});
    go(16'hFE10, 1'b0);
    chk("idle illegal", 16'h0, illegalAddrReset);
    chk("idle valid", 16'h0, selValid);
    $display("hand tests done");
    // Mid-run reset clears a pending illegal request at once
    i_mmdec_cpu.drive(16'hFE10, 1'b1);
    @(posedge clk_sys);
    #2 chk("pre reset illegal", 16'h1, illegalAddrReset);
    reset_n = 0;
    #1 chk("async reset", 16'h0, {selValid, illegalAddrReset});
    chk("async region", 16'h0, decode.region);
    @(posedge clk_sys);
    #1 reset_n = 1;
    go(16'h0000, 1'b1);
    chk("after reset", 16'h2, {zeroPageSel, illegalAddrReset});
    $display("mid reset test done");
    test_done;
  end
endmodule : tb
